// File: mbp_dev_end.sv
/*
 * Device end of the multiplexed byte-wide bus port. Latches the address,
 * decodes read and write cycles in either bus style, drives read data
 * and hands accesses to the register core on a plain user port.
 * Assumes the link pins are synchronous to clk_in and that the core
 * returns acc_rdata_in combinationally from acc_addr_out.
 */
`timescale 1ns/1ns

module mbp_dev_end
    import mbp_pkg::*;
#(
    parameter logic [MBP_RCV_W-1:0] RECOVERY_CYC = MBP_RECOVERY_CYC
) (
    input  wire logic                 clk_in,
    input  wire logic                 sys_rst_in,
    input  wire logic                 clk_en_in,
    input  wire logic                 bus_style_strap_in,
    input  wire logic                 power_fail_in,
    input  wire logic                 ext_reset_n_in,
    input  wire logic [MBP_BUS_W-1:0] acc_rdata_in,
    mbp_bus_if.dev                    bus,
    output logic      [MBP_BUS_W-1:0] acc_addr_out,
    output logic      [MBP_BUS_W-1:0] acc_wdata_out,
    output logic                      acc_wr_out,
    output logic                      acc_rd_out,
    output logic                      strobe_mode_out,
    output logic                      access_ok_out
);

    // =====================================================================
    // State
    logic                 strap_done_q;
    logic                 strobe_mode_q;
    logic [MBP_RCV_W-1:0] rcv_cnt_q;
    logic                 as_q;
    logic                 ds_q;
    logic                 rw_q;
    logic [MBP_BUS_W-1:0] ad_q;
    logic [MBP_BUS_W-1:0] addr_q;
    logic                 addr_valid_q;
    logic [MBP_BUS_W-1:0] wdata_q;
    logic                 wr_q;
    logic                 rd_q;
    logic [MBP_BUS_W-1:0] rdata_q;
    mbp_dev_st_t          st_q;

    // =====================================================================
    // Edge detection against the previous sample of the two strobes and the direction line.
    wire as_rise = bus.addr_latch_strobe & ~as_q;
    wire as_fall = ~bus.addr_latch_strobe & as_q;
    wire ds_rise = bus.data_strobe & ~ds_q;
    wire ds_fall = ~bus.data_strobe & ds_q;
    wire rw_rise = bus.rw & ~rw_q;

    // Recovery is done once the counter has reached its full count.
    wire rcv_done = (rcv_cnt_q == RECOVERY_CYC);

    // The effective chip select: power fail, external reset and the
    // recovery interval all mask the pin before any decode sees it.
    wire access_ok = ~power_fail_in & ext_reset_n_in & rcv_done & strap_done_q;
    wire cs_ok     = ~bus.cs_n & access_ok;

    // Write edge: strobe fall with direction low, or write-enable release.
    wire wr_edge_strb = ds_fall & ~rw_q;
    wire wr_edge_enb  = rw_rise;
    wire wr_edge      = strobe_mode_q ? wr_edge_strb : wr_edge_enb;

    // Read start: strobe rises with direction high, or output enable falls
    // while write enable is inactive.
    wire rd_edge_strb = ds_rise & bus.rw;
    wire rd_edge_enb  = ds_fall & bus.rw;
    wire rd_edge      = strobe_mode_q ? rd_edge_strb : rd_edge_enb;

    // Read end: the opposite strobe transition of each style.
    wire rd_end = strobe_mode_q ? ds_fall : ds_rise;

    // Window in which read data may stand on the shared lines.
    wire rd_window = strobe_mode_q ? (bus.data_strobe & bus.rw)
                                   : (~bus.data_strobe & bus.rw);

    // An attempt consumes the address whether selected or not, so a
    // deselected cycle leaves the host needing a fresh address strobe.
    wire attempt = (wr_edge | rd_edge) & addr_valid_q;
    wire do_wr   = wr_edge & addr_valid_q & cs_ok;
    wire do_rd   = rd_edge & addr_valid_q & cs_ok;

    // =====================================================================
    // Bus style strap, taken once in the first enabled cycle after reset
    // release; changing the strap later has no effect until reset.
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            strap_done_q  <= 1'h0;
            strobe_mode_q <= 1'h0;
        end else if (clk_en_in && !strap_done_q) begin
            strap_done_q  <= 1'h1;
            strobe_mode_q <= bus_style_strap_in;
        end
    end

    // =====================================================================
    // Power-up recovery timer. Any enabled power-fail cycle restarts it, so a
    // brownout shorter than the interval still costs a full recovery.
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rcv_cnt_q <= MBP_RCV_ZERO;
        end else if (clk_en_in) begin
            if (power_fail_in) begin
                rcv_cnt_q <= MBP_RCV_ZERO;
            end else if (!rcv_done) begin
                rcv_cnt_q <= rcv_cnt_q + MBP_RCV_ONE;
            end
        end
    end

    // =====================================================================
    // Previous samples of the link lines. Data is taken from the sample
    // before the edge because the host may drop it with zero hold time.
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            as_q <= 1'h0;
            ds_q <= 1'h0;
            rw_q <= 1'h1;
            ad_q <= MBP_BYTE0;
        end else if (clk_en_in) begin
            as_q <= bus.addr_latch_strobe;
            ds_q <= bus.data_strobe;
            rw_q <= bus.rw;
            ad_q <= bus.muxed_addr_data_bus;
        end
    end

    // =====================================================================
    // Address latch. The rising strobe clears it regardless of chip select;
    // the falling strobe loads it regardless of chip select.
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            addr_q       <= MBP_BYTE0;
            addr_valid_q <= 1'h0;
        end else if (clk_en_in) begin
            if (as_rise) begin
                addr_q       <= MBP_BYTE0;
                addr_valid_q <= 1'h0;
            end else if (as_fall) begin
                addr_q       <= ad_q;
                addr_valid_q <= 1'h1;
            end else if (attempt) begin
                addr_valid_q <= 1'h0;
            end
        end
    end

    // =====================================================================
    // Access pulses and write data towards the register core.
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            wr_q    <= 1'h0;
            rd_q    <= 1'h0;
            wdata_q <= MBP_BYTE0;
        end else if (clk_en_in) begin
            wr_q <= do_wr;
            rd_q <= do_rd;
            if (do_wr) begin
                wdata_q <= ad_q;
            end
        end
    end

    // =====================================================================
    // Read state: data is frozen at the start of the read so the byte on
    // the bus cannot change under the host while it samples.
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st_q    <= MBP_D_IDLE;
            rdata_q <= MBP_BYTE0;
        end else if (clk_en_in) begin
            case (st_q)
                MBP_D_IDLE: begin
                    if (do_rd) begin
                        st_q    <= MBP_D_READ;
                        rdata_q <= acc_rdata_in;
                    end
                end
                MBP_D_READ: begin
                    if (rd_end || !cs_ok) begin
                        st_q <= MBP_D_IDLE;
                    end
                end
                default: begin
                    st_q <= MBP_D_IDLE;
                end
            endcase
        end
    end

    // =====================================================================
    // Link and user-side outputs.
    assign bus.dev_ad    = rdata_q;
    assign bus.dev_ad_oe = (st_q == MBP_D_READ) & rd_window & cs_ok;

    assign acc_addr_out    = addr_q;
    assign acc_wdata_out   = wdata_q;
    assign acc_wr_out      = wr_q;
    assign acc_rd_out      = rd_q;
    assign strobe_mode_out = strobe_mode_q;
    assign access_ok_out   = access_ok;

endmodule

// File: mbp_pkg.sv
/*
 * Shared constants for the multiplexed byte-wide bus port: bus width,
 * one-hot state codes of both ends, clock rate and timing counts.
 * Assumes a single 20 MHz clock on both ends of the link.
 */
package mbp_pkg;

    // =====================================================================
    // Bus shape
    localparam int unsigned MBP_BUS_W  = 8;
    localparam logic [7:0]  MBP_BYTE0  = 8'h00;
    localparam logic [7:0]  MBP_FLOAT  = 8'hFF;

    // =====================================================================
    // Clock and timing figures, each in its own unit
    localparam int unsigned MBP_CLK_NS   = 50;
    localparam int unsigned MBP_T_RPU_MS = 20;
    localparam int unsigned MBP_PWASH_NS = 60;
    localparam int unsigned MBP_PULSE_NS = 150;

    // Power-up recovery: a least time, so it rounds up.
    localparam int unsigned MBP_RCV_W = 19;
    localparam logic [MBP_RCV_W-1:0] MBP_RECOVERY_CYC =
        MBP_RCV_W'((MBP_T_RPU_MS * 1000000 + MBP_CLK_NS - 1) / MBP_CLK_NS);
    localparam logic [MBP_RCV_W-1:0] MBP_RCV_ZERO = 19'h0_0000;
    localparam logic [MBP_RCV_W-1:0] MBP_RCV_ONE  = 19'h0_0001;

    // Host phase timer: least widths, rounded up to whole cycles.
    localparam int unsigned MBP_TMR_W = 4;
    localparam logic [MBP_TMR_W-1:0] MBP_AS_CYC =
        MBP_TMR_W'((MBP_PWASH_NS + MBP_CLK_NS - 1) / MBP_CLK_NS);
    localparam logic [MBP_TMR_W-1:0] MBP_PULSE_CYC =
        MBP_TMR_W'((MBP_PULSE_NS + MBP_CLK_NS - 1) / MBP_CLK_NS);
    localparam logic [MBP_TMR_W-1:0] MBP_TMR_ZERO = 4'h0;
    localparam logic [MBP_TMR_W-1:0] MBP_TMR_ONE  = 4'h1;

    // =====================================================================
    // Device end read state
    typedef enum logic [1:0] {
        MBP_D_IDLE = 2'h1,
        MBP_D_READ = 2'h2
    } mbp_dev_st_t;

    // =====================================================================
    // Host end bus cycle state
    typedef enum logic [4:0] {
        MBP_H_IDLE  = 5'h01,
        MBP_H_ADDR  = 5'h02,
        MBP_H_AHOLD = 5'h04,
        MBP_H_STRB  = 5'h08,
        MBP_H_END   = 5'h10
    } mbp_host_st_t;

endpackage

// File: mbp_bus_if.sv
/*
 * The link between host end and device end: control lines and the shared
 * address/data lines, split into output, enable and resolved level.
 * Assumes at most one end enables its drivers at a time; a floating
 * bus reads as all ones.
 */
`timescale 1ns/1ns

interface mbp_bus_if;
    import mbp_pkg::*;

    logic                 cs_n;
    logic                 addr_latch_strobe;
    logic                 data_strobe;
    logic                 rw;
    logic [MBP_BUS_W-1:0] host_ad;
    logic                 host_ad_oe;
    logic [MBP_BUS_W-1:0] dev_ad;
    logic                 dev_ad_oe;
    logic [MBP_BUS_W-1:0] muxed_addr_data_bus;

    // =====================================================================
    // Wire resolution; the device wins only if both drive, which is a fault.
    assign muxed_addr_data_bus = dev_ad_oe  ? dev_ad  :
                                 host_ad_oe ? host_ad : MBP_FLOAT;

    modport dev (
        input  cs_n,
        input  addr_latch_strobe,
        input  data_strobe,
        input  rw,
        input  muxed_addr_data_bus,
        output dev_ad,
        output dev_ad_oe
    );

    modport host (
        output cs_n,
        output addr_latch_strobe,
        output data_strobe,
        output rw,
        output host_ad,
        output host_ad_oe,
        input  muxed_addr_data_bus
    );
endinterface

// File: mbp_host_end.sv
/*
 * Host end of the multiplexed byte-wide bus port. Runs one complete bus
 * cycle per request: address strobe, then a read or write data phase in
 * the selected bus style.
 * Assumes strobe_mode_in matches the device strap and the device answers
 * within the data phase.
 */
`timescale 1ns/1ns

module mbp_host_end
    import mbp_pkg::*;
(
    input  wire logic                 clk_in,
    input  wire logic                 sys_rst_in,
    input  wire logic                 clk_en_in,
    input  wire logic                 strobe_mode_in,
    input  wire logic                 req_valid_in,
    input  wire logic                 req_write_in,
    input  wire logic [MBP_BUS_W-1:0] req_addr_in,
    input  wire logic [MBP_BUS_W-1:0] req_wdata_in,
    output logic                      req_ready_out,
    output logic                      done_out,
    output logic      [MBP_BUS_W-1:0] rdata_out,
    mbp_bus_if.host                   bus
);

    // =====================================================================
    // State
    mbp_host_st_t         st_q;
    logic [MBP_TMR_W-1:0] tmr_q;
    logic                 wr_q;
    logic [MBP_BUS_W-1:0] ad_q;
    logic [MBP_BUS_W-1:0] wdata_q;
    logic [MBP_BUS_W-1:0] rdata_q;
    logic                 done_q;

    // =====================================================================
    // Phase decode.
    wire in_idle  = (st_q == MBP_H_IDLE);
    wire in_addr  = (st_q == MBP_H_ADDR);
    wire in_ahold = (st_q == MBP_H_AHOLD);
    wire in_strb  = (st_q == MBP_H_STRB);
    wire in_end   = (st_q == MBP_H_END);
    wire accept   = in_idle & req_valid_in;
    wire tmr_last_as  = (tmr_q == MBP_AS_CYC - MBP_TMR_ONE);
    wire tmr_last_pls = (tmr_q == MBP_PULSE_CYC - MBP_TMR_ONE);

    // =====================================================================
    // Bus cycle sequencer. Every access opens with its own address strobe,
    // which also covers a retry after a deselected cycle.
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st_q  <= MBP_H_IDLE;
            tmr_q <= MBP_TMR_ZERO;
        end else if (clk_en_in) begin
            tmr_q <= tmr_q + MBP_TMR_ONE;
            case (st_q)
                MBP_H_IDLE: begin
                    tmr_q <= MBP_TMR_ZERO;
                    if (accept) begin
                        st_q <= MBP_H_ADDR;
                    end
                end
                MBP_H_ADDR: begin
                    if (tmr_last_as) begin
                        st_q <= MBP_H_AHOLD;
                    end
                end
                MBP_H_AHOLD: begin
                    tmr_q <= MBP_TMR_ZERO;
                    st_q  <= MBP_H_STRB;
                end
                MBP_H_STRB: begin
                    if (tmr_last_pls) begin
                        st_q <= MBP_H_END;
                    end
                end
                MBP_H_END: begin
                    st_q <= MBP_H_IDLE;
                end
                default: begin
                    st_q <= MBP_H_IDLE;
                end
            endcase
        end
    end

    // =====================================================================
    // Request capture, address then data on the shared lines, and the
    // read byte sampled in the last cycle of the data phase.
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            wr_q    <= 1'h0;
            ad_q    <= MBP_BYTE0;
            wdata_q <= MBP_BYTE0;
            rdata_q <= MBP_BYTE0;
            done_q  <= 1'h0;
        end else if (clk_en_in) begin
            done_q <= in_end;
            if (accept) begin
                wr_q    <= req_write_in;
                ad_q    <= req_addr_in;
                wdata_q <= req_wdata_in;
            end else if (in_ahold) begin
                ad_q <= wdata_q;
            end
            if (in_strb && tmr_last_pls && !wr_q) begin
                rdata_q <= bus.muxed_addr_data_bus;
            end
        end
    end

    // =====================================================================
    // Pin levels decoded from the one-hot state. In strobe style the
    // direction is set one cycle ahead of the strobe for setup margin.
    wire rw_strb = ~(wr_q & (in_ahold | in_strb | in_end));
    wire rw_enb  = ~(wr_q & in_strb);
    wire ds_strb = in_strb;
    wire ds_enb  = ~(in_strb & ~wr_q);

    assign bus.cs_n              = in_idle;
    assign bus.addr_latch_strobe = in_addr;
    assign bus.data_strobe       = strobe_mode_in ? ds_strb : ds_enb;
    assign bus.rw                = strobe_mode_in ? rw_strb : rw_enb;
    assign bus.host_ad           = ad_q;
    assign bus.host_ad_oe        = in_addr | in_ahold | (wr_q & (in_strb | in_end));

    assign req_ready_out = in_idle;
    assign done_out      = done_q;
    assign rdata_out     = rdata_q;

endmodule

// File: mbp_bus_assertions.sv
/*
 * Concurrent checks on the link between host end and device end.
 * Assumes it is instantiated beside the interface, on the bench clock and reset.
 */
`timescale 1ns/1ns

module mbp_bus_assertions
    import mbp_pkg::*;
(
    input wire logic                 clk_in,
    input wire logic                 sys_rst_in,
    input wire logic                 cs_n,
    input wire logic                 addr_latch_strobe,
    input wire logic                 data_strobe,
    input wire logic                 rw,
    input wire logic [MBP_BUS_W-1:0] host_ad,
    input wire logic                 host_ad_oe,
    input wire logic [MBP_BUS_W-1:0] dev_ad,
    input wire logic                 dev_ad_oe
);
    // ======================================================================
    // Properties
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    // Device drives only inside a selected read window, never during the address.
    a_read_drive_window: assert property (dev_ad_oe |-> rw && !cs_n && !addr_latch_strobe)
        else $error("device drove the bus outside a read window");
    // Two drivers at once would corrupt the shared lines.
    a_no_bus_fight: assert property (!(dev_ad_oe && host_ad_oe))
        else $error("host and device drove the bus together");
    // The sample where the strobe moves already sees the device off the bus.
    a_read_ends_edge: assert property ($changed(data_strobe) |-> !dev_ad_oe)
        else $error("device still drove the bus as the strobe moved");
    // Chip select stays low for the hold and data phases after the address.
    a_cs_whole_access: assert property ($fell(addr_latch_strobe) && !cs_n |-> !cs_n [*5])
        else $error("chip select released inside an access");
    // Every selected cycle opens with an address strobe.
    a_fresh_addr: assert property ($fell(cs_n) |-> addr_latch_strobe)
        else $error("access started without an address strobe");
    // The address strobe lasts two cycles.
    a_as_width: assert property ($rose(addr_latch_strobe) |-> addr_latch_strobe [*2] ##1 !addr_latch_strobe)
        else $error("address strobe width wrong");
    // The host presents the address while the strobe is high.
    a_addr_on_bus: assert property (addr_latch_strobe |-> host_ad_oe && !dev_ad_oe)
        else $error("address not on the bus during the strobe");
    // Both ends leave the bus once the cycle closes.
    a_release_end: assert property ($rose(cs_n) |-> !dev_ad_oe ##1 !host_ad_oe)
        else $error("bus still driven after the cycle");

    // ======================================================================
    // Main scenarios
    c_read: cover property ($rose(dev_ad_oe));
    c_write: cover property (!rw && $fell(data_strobe) && !cs_n);
    c_rw_rise: cover property ($rose(rw) && !cs_n);
endmodule

// File: multiplexed_bus_port_test.sv
/*
 * Self-checking bench: host end and device end joined by one interface, plus
 * a second device end driven by the bench with deliberately bad cycles.
 * Assumes the design files and package are compiled before this one.
 */
`timescale 1ns/1ns

module multiplexed_bus_port_test;
    import mbp_pkg::*;
    localparam logic [MBP_RCV_W-1:0] RCV = 19'h0_0010;
    localparam logic [11:0] SEQ2 [0:14] = '{12'hD40, 12'h940, 12'h877, 12'hA77, 12'h877,
        12'h077, 12'h277, 12'h077, 12'h977, 12'h541, 12'h141, 12'h078, 12'h278, 12'h078, 12'h978};

    logic       clk_in, sys_rst_in, strap, pf, ext_n, run, rq_v, rq_w, rdy, done, wr, rd;
    logic       smode, ok, wr2;
    logic [7:0] rq_a, rq_d, rdata, acc_a, acc_d, acc_a2, acc_d2, q, wr_a, wr_d, wr2_a, wr2_d;
    logic [7:0] wr_cnt, wr2_cnt, seen_addr, c0, rd_cnt, r0;
    int         fail_count, n_tests, cyc, m;

    mbp_bus_if bus();
    mbp_bus_if bus2();

    mbp_host_end mbp_host_end_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .clk_en_in(run),
        .strobe_mode_in(strap), .req_valid_in(rq_v), .req_write_in(rq_w), .req_addr_in(rq_a),
        .req_wdata_in(rq_d), .req_ready_out(rdy), .done_out(done), .rdata_out(rdata), .bus(bus.host));
    mbp_dev_end #(.RECOVERY_CYC(RCV)) mbp_dev_end_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .clk_en_in(run), .bus_style_strap_in(strap), .power_fail_in(pf), .ext_reset_n_in(ext_n),
        .acc_rdata_in(acc_a ^ 8'h5A), .bus(bus.dev), .acc_addr_out(acc_a), .acc_wdata_out(acc_d),
        .acc_wr_out(wr), .acc_rd_out(rd), .strobe_mode_out(smode), .access_ok_out(ok));
    mbp_dev_end #(.RECOVERY_CYC(RCV)) mbp_dev_end_inst2 (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .clk_en_in(run), .bus_style_strap_in(1'b1), .power_fail_in(pf), .ext_reset_n_in(ext_n),
        .acc_rdata_in(8'h00), .bus(bus2.dev), .acc_addr_out(acc_a2), .acc_wdata_out(acc_d2),
        .acc_wr_out(wr2), .acc_rd_out(), .strobe_mode_out(), .access_ok_out());
    mbp_bus_assertions mbp_bus_assertions_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .cs_n(bus.cs_n), .addr_latch_strobe(bus.addr_latch_strobe), .data_strobe(bus.data_strobe),
        .rw(bus.rw), .host_ad(bus.host_ad), .host_ad_oe(bus.host_ad_oe), .dev_ad(bus.dev_ad),
        .dev_ad_oe(bus.dev_ad_oe));

    // ======================================================================
    // Clock.
    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end

    // Record core writes and the last address seen on the wire; also cut a hang.
    always @(posedge clk_in) begin
        cyc++;
        if (wr === 1'b1) begin
            wr_cnt++; wr_a = acc_a; wr_d = acc_d;
        end
        if (rd === 1'b1) rd_cnt++;
        if (wr2 === 1'b1) begin
            wr2_cnt++; wr2_a = acc_a2; wr2_d = acc_d2;
        end
        if (bus.addr_latch_strobe === 1'b1) seen_addr = bus.muxed_addr_data_bus;
        if (cyc == 5000) begin
            fail_count++;
            conclude();
        end
    end

    // ======================================================================
    // Tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            fail_count++;
        end
    endtask

    // One request on the host user port, then a bounded wait for done.
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge clk_in);
        rq_v <= 1'b1; rq_w <= w; rq_a <= a; rq_d <= d;
        @(posedge clk_in);
        rq_v <= 1'b0;
        n = 0;
        do begin
            @(negedge clk_in);
            n++;
            if (n == 1) chk({7'h00, rdy}, 8'h00);
        end while (done !== 1'b1 && n < 20);
        chk({7'h00, done}, 8'h01);
        q = rdata;
        // One more cycle so the core-side pulses have been counted.
        @(negedge clk_in);
    endtask

    // Reset with the strap at the given style; access is refused until recovery.
    task automatic do_reset(input logic s);
        @(posedge clk_in);
        sys_rst_in <= 1'b1; strap <= s;
        repeat (5) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        repeat (4) @(negedge clk_in);
        chk({7'h00, ok}, 8'h00);
        chk({7'h00, bus.cs_n}, 8'h01);
        repeat (20) @(negedge clk_in);
        chk({7'h00, ok}, 8'h01);
        chk({7'h00, smode}, {7'h00, s});
    endtask

    task automatic conclude();
        if (fail_count == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // ======================================================================
    // Main sequence: each bus style in turn, strobe style first, with the faulty far-side cycles run after the strobe style.
    initial begin
        sys_rst_in = 1'b1; strap = 1'b0; pf = 1'b0; ext_n = 1'b1; run = 1'b1;
        rq_v = 1'b0; rq_w = 1'b0; rq_a = 8'h00; rq_d = 8'h00;
        wr_cnt = 8'h00; wr2_cnt = 8'h00; seen_addr = 8'h00; fail_count = 0; n_tests = 0; cyc = 0;
        rd_cnt = 8'h00;
        bus2.cs_n = 1'b1; bus2.addr_latch_strobe = 1'b0; bus2.data_strobe = 1'b0;
        bus2.rw = 1'b1; bus2.host_ad = 8'h00; bus2.host_ad_oe = 1'b1;
        for (m = 1; m >= 0; m--) begin
            do_reset(m[0]);
            c0 = wr_cnt;
            r0 = rd_cnt;
            access(1'b1, 8'h12, 8'hA5);
            chk(wr_cnt, c0 + 8'h01);
            chk(wr_a, 8'h12);
            chk(wr_d, 8'hA5);
            chk(seen_addr, 8'h12);
            access(1'b0, 8'h34, 8'h00);
            chk(q, 8'h34 ^ 8'h5A);
            chk(rd_cnt, r0 + 8'h01);
            chk(wr_cnt, c0 + 8'h01);
            access(1'b1, 8'h00, 8'hFF);
            chk(wr_a, 8'h00);
            chk(wr_d, 8'hFF);
            @(posedge clk_in) ext_n <= 1'b0;
            access(1'b1, 8'h55, 8'h66);
            access(1'b0, 8'h56, 8'h00);
            chk(q, 8'hFF);
            chk(wr_cnt, c0 + 8'h02);
            chk(rd_cnt, r0 + 8'h01);
            @(posedge clk_in) ext_n <= 1'b1;
            pf <= 1'b1;
            access(1'b1, 8'h77, 8'h88);
            chk(wr_cnt, c0 + 8'h02);
            @(posedge clk_in) pf <= 1'b0;
            access(1'b0, 8'h78, 8'h00);
            chk(q, 8'hFF);
            repeat (20) @(posedge clk_in);
            access(1'b0, 8'hC3, 8'h00);
            chk(q, 8'hC3 ^ 8'h5A);
            chk(rd_cnt, r0 + 8'h02);
            if (m == 1) begin
                // The second device sees a deselected write, then a write with a used address.
                for (int i = 0; i < 15; i++) begin
                    @(posedge clk_in);
                    // The address strobe of step 9 has cleared the deselected address.
                    if (i == 10) chk(acc_a2, 8'h00);
                    {bus2.cs_n, bus2.addr_latch_strobe, bus2.data_strobe, bus2.rw} <= SEQ2[i][11:8];
                    bus2.host_ad <= SEQ2[i][7:0];
                    @(posedge clk_in);
                    if (i == 8) chk(wr2_cnt, 8'h00);
                    if (i == 8) chk(acc_a2, 8'h40);
                end
                @(negedge clk_in);
                chk(wr2_cnt, 8'h01);
                chk(wr2_a, 8'h41);
                chk(wr2_d, 8'h78);
            end
        end
        conclude();
    end
endmodule
